// *** pkg/pfp_defines.svh ***
/*
 constants of the pulse fuse programming block: register offsets, field layout, codes, timing.
 assumes a 100 MHz system clock and an Avalon-MM slave with 32-bit data.
*/
// How it works
// - power-up puts controller in initial state
// - intact fuse locations read as zero
// - mid pulses ignored in initial state
// - one high pulse enters parameter selection
// - each mid pulse advances key count, up to three
// - keys one to three select registers
// - high pulse enters addressing for chosen key
// - addressing left only by reset or blow
// - addressed code is temporary until blown
// - high pulse blows addressed bit location
// - gain field six bits, codes 0..63
// - zero-field level six bits, codes 0..63
// - drift trim in low three bits
// - code eight is polarity invert bit
// - code sixteen is lock, freezes all fields
// - code increments per mid pulse, saturates
// - power cycle clears unblown, keeps blown
// - locked device refuses further programming
`ifndef PFP_DEFINES_SVH
`define PFP_DEFINES_SVH
`define PFP_ADDR_W 4
`define PFP_OFS_GAIN 4'h0
`define PFP_OFS_LEVEL 4'h1
`define PFP_OFS_TRIM 4'h2
`define PFP_OFS_STATUS 4'h3
`define PFP_OFS_FUSE_GAIN 4'h4
`define PFP_OFS_FUSE_LEVEL 4'h5
`define PFP_OFS_FUSE_TRIM 4'h6
`define PFP_OFS_ID 4'h7
`define PFP_FIELD_W 6
`define PFP_CODE_MAX 6'h3f
`define PFP_TRIM3_MAX 6'h17
`define PFP_TRIM_LSB 0
`define PFP_TRIM_MSB 2
`define PFP_POL_BIT 3
`define PFP_LOCK_BIT 4
`define PFP_KEY_GAIN 2'h1
`define PFP_KEY_LEVEL 2'h2
`define PFP_KEY_TRIM 2'h3
`define PFP_LVL_LOW 2'h0
`define PFP_LVL_MID 2'h1
`define PFP_LVL_HIGH 2'h2
`define PFP_BLOW_US 30
`define PFP_CLK_MHZ 100
`define PFP_BLOW_CYC (`PFP_BLOW_US * `PFP_CLK_MHZ)
`define PFP_RDATA_ZERO 32'h0000_0000
`endif

// *** pkg/pfp_pkg.sv ***
/*
 types of the pulse fuse programming block.
 assumes nothing beyond the defines header.
*/
package pfp_pkg;
   typedef enum logic [3:0] {
      PFP_ST_INIT = 4'h1,
      PFP_ST_SELECT = 4'h2,
      PFP_ST_ADDR = 4'h4,
      PFP_ST_BLOWN = 4'h8
   } pfp_state_t;
   typedef logic [1:0] pfp_level_t;
endpackage

// *** src/pfp_fuse_fsm.sv ***
/*
 programming controller of a one-time-programmable sensor with an Avalon-MM view.
 assumes the pin level is classified outside and arrives synchronous to sys_clk; reset_n is power-up.
*/
// Chosen here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "pfp_defines.svh"
module pfp_fuse_fsm #(
   parameter int BLOW_CYCLES = `PFP_BLOW_CYC,
   parameter logic [31:0] ID_VALUE = 32'h0000_5a01
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire pfp_pkg::pfp_level_t pin_level,
   input wire logic [`PFP_FIELD_W-1:0] fuse_gain_in,
   input wire logic [`PFP_FIELD_W-1:0] fuse_level_in,
   input wire logic [`PFP_FIELD_W-1:0] fuse_trim_in,
   output logic [`PFP_FIELD_W-1:0] gain_code,
   output logic [`PFP_FIELD_W-1:0] zero_field_output_level,
   output logic [2:0] gain_drift_trim,
   output logic field_direction_invert,
   output logic device_locked,
   output logic fuse_blow_en,
   output logic [1:0] fuse_blow_reg,
   output logic [`PFP_FIELD_W-1:0] fuse_blow_mask,
   input wire logic [`PFP_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   import pfp_pkg::*;

   // the blow counter is sixteen bits wide, so longer blow times cannot be served
   if (BLOW_CYCLES < 1 || BLOW_CYCLES > 65535) begin : g_bad_blow_cycles
      $error("BLOW_CYCLES out of range");
   end

   logic rst_s1_q, rst_n_q;
   pfp_state_t state_q;
   pfp_level_t peak_q;
   logic mid_ev, high_ev;
   logic [1:0] key_q;
   logic [`PFP_FIELD_W-1:0] code_q, code_max;
   logic [`PFP_FIELD_W-1:0] blown_gain_q, blown_level_q, blown_trim_q;
   logic strap_done_q;
   logic [15:0] blow_cnt_q;
   logic [1:0] blow_reg_q;
   logic [`PFP_FIELD_W-1:0] blow_mask_q;
   logic blowing_q;
   logic [`PFP_FIELD_W-1:0] eff_gain, eff_level, eff_trim;
   logic [31:0] rdata_q;
   logic ack_q;
   logic locked;

   // reset released through two flops
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_s1_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q <= rst_s1_q;
      end
   end

   // a pulse counts once the pin falls back to low, taking the highest level seen
   always_ff @(posedge sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         peak_q <= `PFP_LVL_LOW;
      end else if (pin_level == `PFP_LVL_LOW) begin
         peak_q <= `PFP_LVL_LOW;
      end else if (pin_level == `PFP_LVL_HIGH || peak_q == `PFP_LVL_LOW) begin
         peak_q <= pin_level;
      end
   end
   assign mid_ev = (pin_level == `PFP_LVL_LOW) && (peak_q == `PFP_LVL_MID);
   assign high_ev = (pin_level == `PFP_LVL_LOW) && (peak_q == `PFP_LVL_HIGH);

   // blown bits are caught after release; the fuse array holds them through power cycles
   always_ff @(posedge sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         blown_gain_q <= '0;
         blown_level_q <= '0;
         blown_trim_q <= '0;
         strap_done_q <= 1'b0;
      end else if (!strap_done_q) begin
         blown_gain_q <= fuse_gain_in;
         blown_level_q <= fuse_level_in;
         blown_trim_q <= fuse_trim_in;
         strap_done_q <= 1'b1;
      end else if (blowing_q && blow_cnt_q == 16'h0001) begin
         case (blow_reg_q)
            `PFP_KEY_GAIN: blown_gain_q <= blown_gain_q | blow_mask_q;
            `PFP_KEY_LEVEL: blown_level_q <= blown_level_q | blow_mask_q;
            `PFP_KEY_TRIM: blown_trim_q <= blown_trim_q | blow_mask_q;
            default: blown_gain_q <= blown_gain_q;
         endcase
      end
   end

   assign locked = blown_trim_q[`PFP_LOCK_BIT];

   always_comb begin
      case (key_q)
         `PFP_KEY_TRIM: code_max = `PFP_TRIM3_MAX;
         default: code_max = `PFP_CODE_MAX;
      endcase
   end

   // programming controller; only reset leaves the blown state, so a power cycle is expected
   always_ff @(posedge sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         state_q <= PFP_ST_INIT;
         key_q <= 2'h0;
         code_q <= '0;
      end else if (strap_done_q && !locked) begin
         case (state_q)
            PFP_ST_INIT: begin
               if (high_ev) state_q <= PFP_ST_SELECT; // mid pulses ignored
            end
            PFP_ST_SELECT: begin
               if (mid_ev && key_q != `PFP_KEY_TRIM) key_q <= key_q + 2'h1;
               if (high_ev && key_q != 2'h0) state_q <= PFP_ST_ADDR;
            end
            PFP_ST_ADDR: begin
               if (mid_ev && code_q != code_max) code_q <= code_q + 6'h01;
               if (high_ev) state_q <= PFP_ST_BLOWN;
            end
            PFP_ST_BLOWN: state_q <= PFP_ST_BLOWN;
            default: state_q <= PFP_ST_INIT;
         endcase
      end
   end

   // blow strobe held for the blow time; the addressed code is blown as is
   always_ff @(posedge sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         blowing_q <= 1'b0;
         blow_cnt_q <= 16'h0000;
         blow_reg_q <= 2'h0;
         blow_mask_q <= '0;
      end else if (state_q == PFP_ST_ADDR && high_ev && !locked && strap_done_q) begin
         blowing_q <= 1'b1;
         blow_cnt_q <= 16'(BLOW_CYCLES);
         blow_reg_q <= key_q;
         blow_mask_q <= code_q;
      end else if (blowing_q) begin
         blow_cnt_q <= blow_cnt_q - 16'h0001;
         if (blow_cnt_q == 16'h0001) blowing_q <= 1'b0;
      end
   end

   // try value overlays blown bits only while addressing that register
   always_comb begin
      eff_gain = blown_gain_q;
      eff_level = blown_level_q;
      eff_trim = blown_trim_q;
      if (state_q == PFP_ST_ADDR) begin
         case (key_q)
            `PFP_KEY_GAIN: eff_gain = blown_gain_q | code_q;
            `PFP_KEY_LEVEL: eff_level = blown_level_q | code_q;
            `PFP_KEY_TRIM: eff_trim = blown_trim_q | code_q;
            default: eff_gain = blown_gain_q;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         gain_code <= '0;
         zero_field_output_level <= '0;
         gain_drift_trim <= 3'h0;
         field_direction_invert <= 1'b0;
         device_locked <= 1'b0;
         fuse_blow_en <= 1'b0;
         fuse_blow_reg <= 2'h0;
         fuse_blow_mask <= '0;
      end else begin
         gain_code <= eff_gain;
         zero_field_output_level <= eff_level;
         gain_drift_trim <= eff_trim[`PFP_TRIM_MSB:`PFP_TRIM_LSB];
         field_direction_invert <= eff_trim[`PFP_POL_BIT];
         device_locked <= locked;
         fuse_blow_en <= blowing_q;
         fuse_blow_reg <= blow_reg_q;
         fuse_blow_mask <= blow_mask_q;
      end
   end

   // avalon slave: read data one cycle after request, writes ignored (no writable state)
   assign avs_waitrequest = (avs_read || avs_write) && !ack_q;

   always_ff @(posedge sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ack_q <= 1'b0;
         rdata_q <= `PFP_RDATA_ZERO;
      end else begin
         ack_q <= (avs_read || avs_write) && !ack_q;
         if (avs_read && !ack_q) begin
            case (avs_address)
               `PFP_OFS_GAIN: rdata_q <= {26'h0, eff_gain};
               `PFP_OFS_LEVEL: rdata_q <= {26'h0, eff_level};
               `PFP_OFS_TRIM: rdata_q <= {26'h0, eff_trim};
               `PFP_OFS_STATUS: rdata_q <= {17'h0, code_q, key_q, 1'b0, locked,
                  blowing_q, state_q};
               `PFP_OFS_FUSE_GAIN: rdata_q <= {26'h0, blown_gain_q};
               `PFP_OFS_FUSE_LEVEL: rdata_q <= {26'h0, blown_level_q};
               `PFP_OFS_FUSE_TRIM: rdata_q <= {26'h0, blown_trim_q};
               `PFP_OFS_ID: rdata_q <= ID_VALUE; // arbitrary value
               default: rdata_q <= `PFP_RDATA_ZERO;
            endcase
         end
      end
   end
   assign avs_readdata = rdata_q;

endmodule // pfp_fuse_fsm
`default_nettype wire

// *** bench/pfp_fuse_fsm_props.sv ***
/* port checker of the fuse programming controller.
 bound into pfp_fuse_fsm; one clock, reset_n as power-up. */
`timescale 1ns/100ps
`default_nettype none
module pfp_fuse_fsm_props #(
   parameter int BLOW_CYCLES = 5
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic fuse_blow_en,
   input wire logic [1:0] fuse_blow_reg,
   input wire logic [5:0] fuse_blow_mask,
   input wire logic device_locked,
   input wire logic [5:0] gain_code,
   input wire logic [5:0] zero_field_output_level
);
   int cnt_q;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   // blow length is counted, too long for a repetition
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) cnt_q <= 0;
      else cnt_q <= fuse_blow_en ? cnt_q + 1 : 0;
   end
   a_bus_wait_first: assert property ($rose(avs_read | avs_write) |-> avs_waitrequest)
      else $error("no wait cycle");
   a_bus_one_wait: assert property ((avs_read | avs_write) && avs_waitrequest
      |=> !avs_waitrequest)
      else $error("wait too long");
   a_blow_length: assert property ($fell(fuse_blow_en) |-> cnt_q == BLOW_CYCLES)
      else $error("blow too short");
   a_blow_stop: assert property (fuse_blow_en && cnt_q == BLOW_CYCLES - 1 |=> !fuse_blow_en)
      else $error("blow too long");
   a_single_blow: assert property ($fell(fuse_blow_en) |=> !fuse_blow_en [*8])
      else $error("second blow");
   a_blow_hold: assert property (fuse_blow_en && $past(fuse_blow_en) |-> $stable(fuse_blow_mask))
      else $error("blow code moved");
   a_blow_key: assert property (fuse_blow_en |-> fuse_blow_reg != 2'h0 &&
      (fuse_blow_reg != 2'h3 || fuse_blow_mask <= 6'h17))
      else $error("bad blow target");
   a_lock_freeze: assert property (device_locked |=> $stable(gain_code) &&
      $stable(zero_field_output_level) && !$rose(fuse_blow_en))
      else $error("locked fields moved");
endmodule // pfp_fuse_fsm_props
bind pfp_fuse_fsm pfp_fuse_fsm_props #(.BLOW_CYCLES(BLOW_CYCLES)) u_props (.*);
`default_nettype wire

// *** bench/pfp_programmer.sv ***
/* end-of-line programmer model driving classified pin levels.
 assumes a pulse counts when the pin returns low. */
`timescale 1ns/100ps
`default_nettype none
module pfp_programmer (
   input wire logic sys_clk,
   output var pfp_pkg::pfp_level_t pin_level
);
   initial pin_level = 2'h0;
   // three cycles up, three low; high pulses select and blow
   task automatic pulse(input pfp_pkg::pfp_level_t lv, input int n);
      repeat (n) begin
         @(posedge sys_clk);
         pin_level <= lv;
         repeat (3) @(posedge sys_clk);
         pin_level <= 2'h0;
         repeat (3) @(posedge sys_clk);
      end
   endtask
endmodule // pfp_programmer
`default_nettype wire

// *** bench/test_pulse_fuse_programming_fsm.sv ***
/* bench of the fuse programming controller.
 pin pulses come from the programmer model; registers over Avalon-MM. */
`timescale 1ns/100ps
`default_nettype none
`include "pfp_defines.svh"
module test_pulse_fuse_programming_fsm;
   logic sys_clk = 0, reset_n = 0, avs_read = 0, avs_write = 0, avs_waitrequest;
   logic field_direction_invert, device_locked, fuse_blow_en;
   logic [3:0] avs_address = 0;
   logic [31:0] avs_writedata = 0, avs_readdata, rd_q;
   logic [5:0] fuse_gain_in = 0, fuse_level_in = 0, fuse_trim_in = 0, fuse_blow_mask;
   logic [5:0] gain_code, zero_field_output_level;
   logic [2:0] gain_drift_trim;
   logic [1:0] fuse_blow_reg;
   pfp_pkg::pfp_level_t pin_level;
   int n_mismatch = 0, samples_checked = 0;
   initial forever #5 sys_clk = ~sys_clk;
   pfp_programmer prog (.*);
   pfp_fuse_fsm #(.BLOW_CYCLES(5)) dut (.*);
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         n_mismatch++;
      end
   endtask
   // power cycle; straps stand for the fuses blown so far
   task automatic power(input logic [5:0] g, l, t);
      @(posedge sys_clk);
      reset_n <= 0;
      fuse_gain_in <= g;
      fuse_level_in <= l;
      fuse_trim_in <= t;
      repeat (16) @(posedge sys_clk);
      reset_n <= 1;
      repeat (5) @(posedge sys_clk);
   endtask
   task automatic bus(input logic w, input logic [3:0] a);
      int n = 0;
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= w ? 32'h0000_003f : 32'h0000_0000;
      avs_write <= w;
      avs_read <= !w;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0 && ++n < 20);
      if (n >= 20) begin
         $display("wrong value bus answer expected 0 seen 1");
         n_mismatch++;
      end
      rd_q = avs_readdata;
      avs_read <= 0;
      avs_write <= 0;
   endtask
   task automatic hp(input int n);
      prog.pulse(`PFP_LVL_HIGH, n);
   endtask
   task automatic mp(input int n);
      prog.pulse(`PFP_LVL_MID, n);
   endtask
   task automatic sel(input int k, input int c);
      hp(1);
      mp(k);
      hp(1);
      mp(c);
   endtask
   task automatic t_path;
      power(0, 0, 0);
      chk("gain at power-up", 0, gain_code);
      mp(2);
      sel(1, 65);
      chk("gain code", 63, gain_code);
      chk("zero level", 0, zero_field_output_level);
      bus(1, `PFP_OFS_GAIN);
      bus(0, `PFP_OFS_GAIN);
      chk("gain readback", 63, rd_q);
      bus(0, `PFP_OFS_FUSE_GAIN);
      chk("gain fuses", 0, rd_q);
      bus(0, 4'h9);
      chk("unmapped read", 0, rd_q);
      $display("path test done");
   endtask
   task automatic t_blow;
      int n = 0;
      power(0, 0, 0);
      sel(2, 32);
      chk("zero level", 32, zero_field_output_level);
      hp(1);
      while (fuse_blow_en !== 1'b1 && n < 20) begin
         @(posedge sys_clk);
         n++;
      end
      chk("blow register", 2, fuse_blow_reg);
      chk("blow code", 32, fuse_blow_mask);
      repeat (10) @(posedge sys_clk);
      mp(1);
      chk("level after blow", 32, zero_field_output_level);
      bus(0, `PFP_OFS_FUSE_LEVEL);
      chk("level fuses", 32, rd_q);
      power(6'h05, 6'h20, 0);
      chk("gain after cycle", 5, gain_code);
      sel(1, 2);
      chk("gain try", 7, gain_code);
      chk("level kept", 32, zero_field_output_level);
      $display("blow test done");
   endtask
   task automatic t_reg3;
      power(0, 0, 0);
      sel(5, 9);
      chk("drift trim", 1, gain_drift_trim);
      chk("invert", 1, field_direction_invert);
      mp(20);
      chk("drift trim max", 7, gain_drift_trim);
      chk("lock unblown", 0, device_locked);
      power(0, 0, 6'h10);
      chk("locked", 1, device_locked);
      sel(1, 2);
      chk("gain frozen", 0, gain_code);
      $display("lock test done");
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // about twelve hundred cycles are expected
   initial begin
      #100_000;
      n_mismatch++;
      end_sim;
   end
   initial begin
      t_path;
      t_blow;
      t_reg3;
      end_sim;
   end
endmodule // test_pulse_fuse_programming_fsm
`default_nettype wire
